// file: src/ddrg_core.sv
`timescale 1ns/100ps
`include "ddrg_consts.svh"

module ddrg_core #(
    parameter bit X16        = 1'b0,
    parameter int FIFO_DEPTH = `DDRG_FIFO_DEPTH
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_term_mode,
    output ddrg_pkg::ddrg_wb_s               o_wb,
    output logic                             o_wb_valid,
    input  wire logic                        i_wb_ready,
    output logic                             o_wb_lost,
    input  wire logic                        i_true_clock_input,
    input  wire logic                        i_cke,
    input  wire logic                        i_on_die_termination,
    input  ddrg_pkg::ddrg_cmd_s              i_cmd,
    input  wire logic [`DDRG_DQ_W-1:0]       i_dq,
    output logic      [`DDRG_DQ_W-1:0]       o_dq_rise,
    output logic      [`DDRG_DQ_W-1:0]       o_dq_fall,
    output logic                             o_dq_oe,
    output logic                             o_dq_term
);
    import ddrg_pkg::*;

    localparam int DW    = `DDRG_DQ_W;
    localparam int NB    = `DDRG_BEATS;
    localparam int BANKS = X16 ? `DDRG_BANKS_X16 : `DDRG_BANKS_X8;
    localparam int COLS  = 1 << `DDRG_COL_W;
    localparam int DEPTH = BANKS * COLS;
    localparam logic [1:0] LAST = 2'(`DDRG_XFER_CLKS - 1);

    ////////////////////////////////////////////////////////////////////////////
    // link reset: asserts at once, releases on the link clock

    logic lrst_meta_q, lrst_n;

    always_ff @(posedge i_true_clock_input or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lrst_meta_q <= 1'b0;
            lrst_n      <= 1'b0;
        end else begin
            lrst_meta_q <= 1'b1;
            lrst_n      <= lrst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    ddrg_state_e st_q;
    logic [1:0]  cnt_q;
    logic        cmd_act, rd_go, wr_go;
    logic [`DDRG_BANK_W-1:0] bank_sel;
    logic [`DDRG_BANK_W+`DDRG_COL_W-1:0] addr_q;

    // x16 leaves the upper group bit unused, so only eight banks exist
    function automatic logic [`DDRG_BANK_W-1:0] bank_idx(input logic [1:0] bg,
                                                       input logic [1:0] ba);
        if (X16) begin
            bank_idx = {1'b0, bg[0], ba};
        end else begin
            bank_idx = {bg, ba};
        end
    endfunction

    assign cmd_act  = !i_cmd.cs_n && i_cmd.act_n && i_cke && (st_q == ST_IDLE);
    assign rd_go    = cmd_act && ({i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n} == `DDRG_CMD_RD);
    assign wr_go    = cmd_act && ({i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n} == `DDRG_CMD_WR);
    assign bank_sel = bank_idx(i_cmd.bg, i_cmd.ba);

    ////////////////////////////////////////////////////////////////////////////
    // burst sequencer

    always_ff @(posedge i_true_clock_input or negedge lrst_n) begin
        if (!lrst_n) begin
            st_q   <= ST_IDLE;
            cnt_q  <= '0;
            addr_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= '0;
                    if (rd_go || wr_go) begin
                        addr_q <= {bank_sel, i_cmd.col};
                        st_q   <= rd_go ? ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == LAST) begin
                        st_q <= ST_COMMIT;
                    end
                end
                ST_COMMIT: begin
                    st_q <= ST_IDLE;
                end
                ST_READ: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == LAST) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write capture, both clock halves

    logic [DW-1:0]    fall_q;
    logic [DW-1:0]    wbuf_q [NB];
    logic [NB*DW-1:0] wword;
    logic [NB*DW-1:0] mem [DEPTH];
    logic [NB*DW-1:0] rd_word_q;

    // falling half of each pin cycle
    always_ff @(negedge i_true_clock_input or negedge lrst_n) begin
        if (!lrst_n) begin
            fall_q <= '0;
        end else begin
            fall_q <= i_dq;
        end
    end

    always_ff @(posedge i_true_clock_input or negedge lrst_n) begin
        if (!lrst_n) begin
            for (int i = 0; i < NB; i++) begin
                wbuf_q[i] <= '0;
            end
        end else if (st_q == ST_WRITE) begin
            wbuf_q[2*cnt_q] <= i_dq;
            if (cnt_q != 2'h0) begin
                wbuf_q[2*cnt_q-1] <= fall_q;
            end
        end
    end

    // last falling word joins in the commit cycle
    genvar g;
    generate
        for (g = 0; g < NB - 1; g++) begin : g_wword
            assign wword[g*DW +: DW] = wbuf_q[g];
        end
    endgenerate
    assign wword[(NB-1)*DW +: DW] = fall_q;

    always_ff @(posedge i_true_clock_input) begin
        if (st_q == ST_COMMIT) begin
            mem[addr_q] <= wword;
        end
    end

    always_ff @(posedge i_true_clock_input or negedge lrst_n) begin
        if (!lrst_n) begin
            rd_word_q <= '0;
        end else if (rd_go) begin
            rd_word_q <= mem[{bank_sel, i_cmd.col}];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read drive and termination

    logic term_en;

    always_ff @(posedge i_true_clock_input or negedge lrst_n) begin
        if (!lrst_n) begin
            o_dq_rise <= '0;
            o_dq_fall <= '0;
            o_dq_oe   <= 1'b0;
            o_dq_term <= 1'b0;
        end else begin
            o_dq_oe <= (st_q == ST_READ);
            o_dq_term <= (st_q != ST_READ) && i_on_die_termination && term_en;
            if (st_q == ST_READ) begin
                o_dq_rise <= rd_word_q[2*cnt_q*DW +: DW];
                o_dq_fall <= rd_word_q[(2*cnt_q+1)*DW +: DW];
            end
        end
    end

    // mode setting is static; a level crossing is enough
    ddrg_sync #(.W(1)) u_term (
        .i_clk   (i_true_clock_input),
        .i_rst_n (lrst_n),
        .i_d     (i_term_mode),
        .o_q     (term_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mirror of committed writes to the core clock

    ddrg_wb_s wb_in;
    logic     push_ready, lost_q;

    assign wb_in = '{bank: addr_q[`DDRG_BANK_W+`DDRG_COL_W-1:`DDRG_COL_W],
                     col:  addr_q[`DDRG_COL_W-1:0],
                     data: wword};

    // the controller cannot be stalled, so a full buffer drops the copy
    always_ff @(posedge i_true_clock_input or negedge lrst_n) begin
        if (!lrst_n) begin
            lost_q <= 1'b0;
        end else if ((st_q == ST_COMMIT) && !push_ready) begin
            lost_q <= 1'b1;
        end
    end

    ddrg_fifo #(.W($bits(ddrg_wb_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_wclk   (i_true_clock_input),
        .i_wrst_n (lrst_n),
        .i_wvalid (st_q == ST_COMMIT),
        .o_wready (push_ready),
        .i_wdata  (wb_in),
        .i_rclk   (i_clk),
        .i_rrst_n (i_rst_n),
        .o_rvalid (o_wb_valid),
        .i_rready (i_wb_ready),
        .o_rdata  (o_wb)
    );

    ddrg_sync #(.W(1)) u_lost (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (lost_q),
        .o_q     (o_wb_lost)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_rd_beats;
        o_dq_oe [*4] ##1 !o_dq_oe;
    endsequence

    sequence s_wr_beats;
        (st_q == ST_WRITE) [*4] ##1 (st_q == ST_COMMIT);
    endsequence

    a_read_burst_len: assert property (
        @(posedge i_true_clock_input) disable iff (!lrst_n)
        rd_go |=> ##1 s_rd_beats)
        else $error("read burst not four clocks");

    a_write_burst_len: assert property (
        @(posedge i_true_clock_input) disable iff (!lrst_n)
        wr_go |=> s_wr_beats)
        else $error("write burst not four clocks");

    a_read_first_pair: assert property (
        @(posedge i_true_clock_input) disable iff (!lrst_n)
        rd_go |=> ##1 (o_dq_rise == rd_word_q[0 +: DW]
                       && o_dq_fall == rd_word_q[DW +: DW]))
        else $error("first read pair wrong");

    a_bank_in_range: assert property (
        @(posedge i_true_clock_input) disable iff (!lrst_n)
        (rd_go || wr_go) |-> (int'(bank_sel) < BANKS))
        else $error("bank index outside configuration");

    a_term_not_driving: assert property (
        @(posedge i_true_clock_input) disable iff (!lrst_n)
        o_dq_term |-> (!o_dq_oe && $past(term_en) && $past(i_on_die_termination)))
        else $error("termination while driving or disabled");

    a_cmd_sampled: assert property (
        @(posedge i_true_clock_input) disable iff (!lrst_n)
        (st_q == ST_IDLE && i_cmd.cs_n) |=> (st_q == ST_IDLE))
        else $error("deselected slot started a burst");
endmodule

// file: pkg/ddrg_consts.svh
`ifndef DDRG_CONSTS_SVH
`define DDRG_CONSTS_SVH

// pin word width and core word shape
`define DDRG_DQ_W        8
`define DDRG_BEATS       8
`define DDRG_XFER_CLKS   4
`define DDRG_COL_W       2
`define DDRG_BANK_W      4

// bank organisation
`define DDRG_BANKS_X8    16
`define DDRG_BANKS_X16   8
`define DDRG_BANKS_GRP   4

// command codes on {ras_n, cas_n, we_n} with act_n high
`define DDRG_CMD_RD      3'h5
`define DDRG_CMD_WR      3'h4
`define DDRG_CMD_NOOP    3'h7

// mirror buffer
`define DDRG_FIFO_DEPTH  16

`endif

// file: pkg/ddrg_pkg.sv
`include "ddrg_consts.svh"

package ddrg_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_WRITE  = 4'h2,
        ST_COMMIT = 4'h4,
        ST_READ   = 4'h8
    } ddrg_state_e;

    // command and address pins, sampled together
    typedef struct packed {
        logic                   cs_n;
        logic                   act_n;
        logic                   ras_n;
        logic                   cas_n;
        logic                   we_n;
        logic [1:0]             bg;
        logic [1:0]             ba;
        logic [`DDRG_COL_W-1:0] col;
    } ddrg_cmd_s;

    // one committed write burst
    typedef struct packed {
        logic [`DDRG_BANK_W-1:0]               bank;
        logic [`DDRG_COL_W-1:0]                col;
        logic [`DDRG_BEATS*`DDRG_DQ_W-1:0]     data;
    } ddrg_wb_s;

endpackage

// file: src/ddrg_sync.sv
`timescale 1ns/100ps

module ddrg_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule

// file: src/ddrg_fifo.sv
`timescale 1ns/100ps

// dual-clock fifo, gray pointers cross through two-flop synchronisers
module ddrg_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         i_wclk,
    input  wire logic         i_wrst_n,
    input  wire logic         i_wvalid,
    output logic              o_wready,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic         i_rclk,
    input  wire logic         i_rrst_n,
    output logic              o_rvalid,
    input  wire logic         i_rready,
    output logic      [W-1:0] o_rdata
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wbin_q, rbin_q, wgray_q, rgray_q, wgray_r, rgray_w;
    logic [AW:0]  wbin_d, rbin_d;

    assign wbin_d   = wbin_q + (AW+1)'(1);
    assign rbin_d   = rbin_q + (AW+1)'(1);
    // full when the write pointer is one lap ahead of the read pointer
    assign o_wready = (wgray_q != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign o_rvalid = (rgray_q != wgray_r);
    assign o_rdata  = mem[rbin_q[AW-1:0]];

    always_ff @(posedge i_wclk) begin
        if (i_wvalid && o_wready) begin
            mem[wbin_q[AW-1:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_wclk or negedge i_wrst_n) begin
        if (!i_wrst_n) begin
            wbin_q  <= '0;
            wgray_q <= '0;
        end else if (i_wvalid && o_wready) begin
            wbin_q  <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
        end
    end

    always_ff @(posedge i_rclk or negedge i_rrst_n) begin
        if (!i_rrst_n) begin
            rbin_q  <= '0;
            rgray_q <= '0;
        end else if (o_rvalid && i_rready) begin
            rbin_q  <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
        end
    end

    ddrg_sync #(.W(AW+1)) u_w2r (
        .i_clk   (i_rclk),
        .i_rst_n (i_rrst_n),
        .i_d     (wgray_q),
        .o_q     (wgray_r)
    );

    ddrg_sync #(.W(AW+1)) u_r2w (
        .i_clk   (i_wclk),
        .i_rst_n (i_wrst_n),
        .i_d     (rgray_q),
        .o_q     (rgray_w)
    );
endmodule

// file: sim/ddrg_ctrl_model.sv
`timescale 1ns/100ps
`include "ddrg_consts.svh"

// controller side of the pins, every change lands just after a link edge
module ddrg_ctrl_model (
    input  wire logic                  i_ck,
    input  wire logic [`DDRG_DQ_W-1:0] i_dq_rise,
    input  wire logic [`DDRG_DQ_W-1:0] i_dq_fall,
    input  wire logic                  i_dq_oe,
    input  wire logic                  i_dq_term,
    output logic                       o_cke,
    output logic                       o_odt,
    output ddrg_pkg::ddrg_cmd_s        o_cmd,
    output logic [`DDRG_DQ_W-1:0]      o_dq
);
    import ddrg_pkg::*;
    localparam time DLY = 1;
    localparam int  DW  = `DDRG_BEATS*`DDRG_DQ_W;

    function automatic ddrg_cmd_s mk(input logic cs_n, input logic act_n,
                                     input logic [2:0] code, input logic [3:0] bank,
                                     input logic [1:0] col);
        return ddrg_cmd_s'({cs_n, act_n, code, bank, col});
    endfunction

    function automatic ddrg_cmd_s des();
        return mk(1'b1, 1'b1, `DDRG_CMD_NOOP, 4'h0, 2'h0);
    endfunction

    initial begin
        o_cke = 1'b0;
        o_odt = 1'b0;
        o_cmd = des();
        o_dq  = 8'h5a;
    end

    task automatic step();
        @(posedge i_ck);
        #DLY;
    endtask

    task automatic idle(input int n);
        repeat (n) step();
    endtask

    // clock enable toggles: low in reset, high after, probes drop it
    task automatic go();
        step();
        o_cke = 1'b1;
        idle(3);
    endtask

    task automatic set_odt(input logic v);
        step();
        o_odt = v;
    endtask

    task automatic wr(input logic [3:0] bank, input logic [1:0] col,
                      input logic [DW-1:0] data, input bit intrude, output bit seen);
        seen = 1'b0;
        step();
        o_cmd = mk(1'b0, 1'b1, `DDRG_CMD_WR, bank, col);
        // first rise beat belongs to the edge after the command edge
        step();
        o_cmd = intrude ? mk(1'b0, 1'b1, `DDRG_CMD_RD, bank, col) : des();
        // data goes out one byte per half clock on the 8-bit lane, beat 0 first
        o_dq = data[7:0];
        for (int k = 1; k < `DDRG_BEATS; k++) begin
            if (k % 2 == 1) begin
                @(posedge i_ck);
            end else begin
                @(negedge i_ck);
            end
            #DLY;
            o_dq = data[8*k +: 8];
            if (k == 1) begin
                o_cmd = des();
            end
            if (i_dq_oe !== 1'b0) begin
                seen = 1'b1;
            end
        end
        @(negedge i_ck);
        #DLY;
        // released line flips so a stale beat cannot pass for data
        o_dq = ~o_dq;
        // let the commit edge go by before the next slot
        @(posedge i_ck);
    endtask

    task automatic rd(input logic [3:0] bank, input logic [1:0] col,
                      output logic [DW-1:0] data, output bit ok);
        step();
        o_cmd = mk(1'b0, 1'b1, `DDRG_CMD_RD, bank, col);
        step();
        o_cmd = des();
        ok = (i_dq_oe === 1'b0);
        for (int j = 0; j < `DDRG_XFER_CLKS; j++) begin
            step();
            data[16*j +: 16] = {i_dq_fall, i_dq_rise};
            if (i_dq_oe !== 1'b1 || i_dq_term !== 1'b0) begin
                ok = 1'b0;
            end
        end
        step();
        if (i_dq_oe !== 1'b0) begin
            ok = 1'b0;
        end
    endtask

    task automatic probe(input ddrg_cmd_s c, input logic cke, output bit seen);
        seen = 1'b0;
        step();
        o_cke = cke;
        o_cmd = c;
        step();
        o_cke = 1'b1;
        o_cmd = des();
        repeat (7) begin
            step();
            if (i_dq_oe !== 1'b0) begin
                seen = 1'b1;
            end
        end
    endtask
endmodule

// file: sim/ddrg_core_tb_top.sv
`timescale 1ns/100ps
`include "ddrg_consts.svh"

module ddrg_core_tb_top;
    import ddrg_pkg::*;
    localparam int DW = `DDRG_BEATS*`DDRG_DQ_W;

    logic                  i_clk;
    logic                  i_rst_n;
    logic                  i_term_mode;
    logic                  i_wb_ready;
    logic                  ck;
    ddrg_wb_s              o_wb;
    logic                  o_wb_valid;
    logic                  o_wb_lost;
    logic                  cke;
    logic                  on_die_termination;
    ddrg_cmd_s             cmd;
    logic [`DDRG_DQ_W-1:0] dq;
    logic [`DDRG_DQ_W-1:0] dq_rise;
    logic [`DDRG_DQ_W-1:0] dq_fall;
    logic                  dq_oe;
    logic                  dq_term;
    int                    n_errors;
    int                    n_tests;

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // link clock offset by 3 ns, though its edges still meet the core clock's every 120 ns (first at 75 ns)
    initial begin
        ck = 1'b0;
        #3;
        forever #24 ck = ~ck;
    end

    ddrg_core #(.X16(1'b0), .FIFO_DEPTH(`DDRG_FIFO_DEPTH)) ddrg_core_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_term_mode(i_term_mode), .o_wb(o_wb),
        .o_wb_valid(o_wb_valid), .i_wb_ready(i_wb_ready), .o_wb_lost(o_wb_lost),
        .i_true_clock_input(ck), .i_cke(cke), .i_on_die_termination(on_die_termination), .i_cmd(cmd),
        .i_dq(dq), .o_dq_rise(dq_rise), .o_dq_fall(dq_fall), .o_dq_oe(dq_oe),
        .o_dq_term(dq_term));

    ddrg_ctrl_model ddrg_ctrl_model_inst (
        .i_ck(ck), .i_dq_rise(dq_rise), .i_dq_fall(dq_fall), .i_dq_oe(dq_oe),
        .i_dq_term(dq_term), .o_cke(cke), .o_odt(on_die_termination), .o_cmd(cmd), .o_dq(dq));

    function automatic logic [DW-1:0] pat(input int i);
        logic [DW-1:0] p;
        for (int k = 0; k < `DDRG_BEATS; k++) begin
            p[8*k +: 8] = 8'(i * 8 + k);
        end
        return p;
    endfunction

    task automatic tally_and_finish();
        $display("mismatches %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input bit c, input string msg);
        n_tests++;
        if (!c) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic pop_check(input logic [3:0] bk, input logic [1:0] cl, input logic [DW-1:0] d);
        int t;
        for (t = 0; t < 50 && o_wb_valid !== 1'b1; t++) begin
            @(posedge i_clk);
            #1;
        end
        if (t == 50) begin
            check(1'b0, "mirror entry never showed");
            tally_and_finish();
        end
        check(o_wb.bank === bk && o_wb.col === cl && o_wb.data === d, "mirror entry");
        i_wb_ready = 1'b1;
        @(posedge i_clk);
        #1;
        i_wb_ready = 1'b0;
    endtask

    task automatic s_reset();
        repeat (6) @(posedge ck);
        #1;
        check(o_wb_valid === 1'b0 && o_wb_lost === 1'b0 && dq_oe === 1'b0, "busy in reset");
        i_rst_n = 1'b1;
        ddrg_ctrl_model_inst.go();
    endtask

    task automatic s_banks();
        logic [3:0]    bk [5] = '{4'hf, 4'hb, 4'h7, 4'h3, 4'h0};
        logic [1:0]    cl [5] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0};
        logic [DW-1:0] got;
        bit            f;
        for (int i = 0; i < 5; i++) begin
            ddrg_ctrl_model_inst.wr(bk[i], cl[i], pat(i), 1'b0, f);
            pop_check(bk[i], cl[i], pat(i));
        end
        for (int i = 0; i < 5; i++) begin
            ddrg_ctrl_model_inst.rd(bk[i], cl[i], got, f);
            check(f, "read burst timing");
            check(got === pat(i), "read data or bank");
        end
    endtask

    task automatic s_refuse();
        bit f;
        for (int i = 0; i < 5; i++) begin
            ddrg_ctrl_model_inst.probe(ddrg_ctrl_model_inst.mk(i == 0, i != 1,
                (i == 2) ? `DDRG_CMD_NOOP : `DDRG_CMD_RD, 4'hf, 2'h3), i != 3, f);
            check(f == (i == 4), "probe reply");
        end
        ddrg_ctrl_model_inst.wr(4'h5, 2'h1, pat(9), 1'b1, f);
        check(!f, "read taken in mid burst");
        pop_check(4'h5, 2'h1, pat(9));
        repeat (5) @(posedge i_clk);
        #1;
        check(o_wb_valid === 1'b0, "extra mirror entry");
    endtask

    task automatic s_term();
        logic          md [3] = '{1'b1, 1'b0, 1'b1};
        logic          od [3] = '{1'b0, 1'b1, 1'b1};
        logic [DW-1:0] got;
        bit            f;
        for (int i = 0; i < 3; i++) begin
            i_term_mode = md[i];
            ddrg_ctrl_model_inst.set_odt(od[i]);
            ddrg_ctrl_model_inst.idle(4);
            check(dq_term === (md[i] & od[i]), "termination state");
        end
        ddrg_ctrl_model_inst.rd(4'hf, 2'h3, got, f);
        check(f && got === pat(0), "read while terminating");
    endtask

    task automatic s_fifo();
        bit f;
        for (int i = 0; i <= `DDRG_FIFO_DEPTH; i++) begin
            if (i == `DDRG_FIFO_DEPTH) begin
                ddrg_ctrl_model_inst.idle(1);
                check(o_wb_lost === 1'b0 && o_wb_valid === 1'b1, "drop flagged early");
            end
            ddrg_ctrl_model_inst.wr(4'(i), 2'(i), pat(i + 16), 1'b0, f);
        end
        ddrg_ctrl_model_inst.idle(2);
        check(o_wb_lost === 1'b1, "drop on full not flagged");
        for (int i = 0; i < `DDRG_FIFO_DEPTH; i++) begin
            pop_check(4'(i), 2'(i), pat(i + 16));
        end
        repeat (5) @(posedge i_clk);
        #1;
        check(o_wb_valid === 1'b0, "not empty after drain");
    endtask

    initial begin
        #500us;
        check(1'b0, "run did not end");
        tally_and_finish();
    end

    initial begin
        n_errors = 0;
        n_tests = 0;
        i_rst_n = 1'b0;
        i_term_mode = 1'b0;
        i_wb_ready = 1'b0;
        s_reset();
        s_banks();
        s_refuse();
        s_term();
        s_fifo();
        tally_and_finish();
    end
endmodule
